// ==== rtl/chtreg_top.sv ====
// Purpose: thermistor threshold settings and charger status registers on AHB-Lite
// Assumes: status and comparator inputs are asynchronous pins; zero wait states
// Notes: watchdog and register-reset requests are synchronous one-cycle inputs
`timescale 1ns/1ps
// How it works
// RULE_01 - cool code picks rising threshold fraction
// RULE_02 - warm code picks falling threshold fraction
// RULE_03 - hot code picks limit, three disables
// RULE_04 - cold bit picks minus ten or twenty
// RULE_05 - ignore bit forces good, flags zero
// RULE_06 - report clamped 9-bit current limit, 10mA steps; code reads zero, unclamped, until the first settled change of the limit code
// RULE_07 - bit 7 shows current regulation active
// RULE_08 - bit 6 shows voltage regulation active
// RULE_09 - bit 5 shows watchdog expired
// RULE_10 - bit 3 shows power good
// RULE_11 - bits 2,1 show auxiliary inputs present
// RULE_12 - bit 0 shows main input present
// RULE_13 - read-only writes ignored, reserved read zero
module chtreg_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  input wire logic wdog_reset,
  input wire logic reg_reset,
  input wire logic [8:0] optimized_current_limit,
  input wire logic input_current_reg_flag,
  input wire logic input_voltage_reg_flag,
  input wire logic watchdog_expired_flag,
  input wire logic power_good_flag,
  input wire logic aux_input2_present,
  input wire logic aux_input1_present,
  input wire logic main_input_present,
  input wire logic [3:0] therm_raw_flags,
  output logic [9:0] cool_threshold_permille,
  output logic [9:0] warm_threshold_permille,
  output logic signed [7:0] output_hot_limit_c,
  output logic output_hot_check_en,
  output logic signed [7:0] output_cold_limit_c,
  output logic thermistor_good,
  output logic [3:0] thermistor_flags
);

  chtreg_pkg::chtreg_state_s st;
  chtreg_pkg::chtreg_state_s next_st;
  logic [chtreg_pkg::SYNC_W-1:0] pins;
  logic take;
  logic [7:0] s0_now;
  logic [31:0] rd_val;
  logic rd_stat;
  logic [chtreg_pkg::ICL_W-1:0] icl_s2;
  logic [chtreg_pkg::ICL_W-1:0] icl_s3;
  logic [chtreg_pkg::ICL_W-1:0] icl_lvl;

  assign pins = {therm_raw_flags, optimized_current_limit, input_current_reg_flag,
                 input_voltage_reg_flag, watchdog_expired_flag, power_good_flag,
                 aux_input2_present, aux_input1_present, main_input_present};
  assign take = hsel && hready && htrans[1];
  assign icl_s2 = st.s2[chtreg_pkg::ICL_SYNC_LSB +: chtreg_pkg::ICL_W];
  assign icl_s3 = st.s3[chtreg_pkg::ICL_SYNC_LSB +: chtreg_pkg::ICL_W];
  assign icl_lvl = st.lvl[chtreg_pkg::ICL_SYNC_LSB +: chtreg_pkg::ICL_W];

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_st = st;
    // three-stage pin sync; a level counts once stages two and three agree
    next_st.s1 = pins;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < chtreg_pkg::SYNC_W; i++)
    begin
      if (st.s2[i] == st.s3[i])
        next_st.lvl[i] = st.s3[i];
    end
    // the limit word moves as a whole: bit-wise agreement could latch a torn code
    // until the first settled change the register keeps its reset value of zero
    next_st.lvl[chtreg_pkg::ICL_SYNC_LSB +: chtreg_pkg::ICL_W] = icl_lvl;
    if (icl_s2 == icl_s3 && icl_s3 != icl_lvl)
    begin
      next_st.lvl[chtreg_pkg::ICL_SYNC_LSB +: chtreg_pkg::ICL_W] = icl_s3;
      if (icl_s3 < chtreg_pkg::ICL_MIN)
        next_st.icl = chtreg_pkg::ICL_MIN; // RULE_06
      else if (icl_s3 > chtreg_pkg::ICL_MAX)
        next_st.icl = chtreg_pkg::ICL_MAX; // RULE_06
      else
        next_st.icl = icl_s3; // RULE_06
    end
    s0_now = 8'h00;
    s0_now[chtreg_pkg::ST_ICUR] = st.lvl[6]; // RULE_07
    s0_now[chtreg_pkg::ST_VREG] = st.lvl[5]; // RULE_08
    s0_now[chtreg_pkg::ST_WD] = st.lvl[4]; // RULE_09
    s0_now[chtreg_pkg::ST_PG] = st.lvl[3]; // RULE_10
    s0_now[chtreg_pkg::ST_AUX2] = st.lvl[2]; // RULE_11
    s0_now[chtreg_pkg::ST_AUX1] = st.lvl[1]; // RULE_11
    s0_now[chtreg_pkg::ST_MAIN] = st.lvl[0]; // RULE_12
    next_st.stat0 = s0_now;
    next_st.stat0_prev = st.stat0;
    // bus address phase
    if (take)
    begin
      next_st.phase = chtreg_pkg::CHTREG_DATA;
      next_st.wr = hwrite;
      next_st.idx = haddr[9:2];
    end
    else if (hready)
    begin
      next_st.phase = chtreg_pkg::CHTREG_IDLE;
    end
    // read data prepared at address phase
    rd_val = 32'h0000_0000;
    rd_stat = 1'b0;
    if (take && !hwrite)
    begin
      case (haddr[9:2])
        chtreg_pkg::IDX_THERM_CTRL: rd_val = {24'h000000, st.therm_ctrl};
        chtreg_pkg::IDX_ICL: rd_val = {23'h000000, st.icl}; // RULE_13
        chtreg_pkg::IDX_STAT0: rd_val = {24'h000000, st.stat0}; // RULE_13
        chtreg_pkg::IDX_STAT1: rd_val = 32'h0000_0000; // RULE_13
        chtreg_pkg::IDX_EVT_STAT:
        begin
          rd_val = {24'h000000, st.evt};
          rd_stat = 1'b1;
        end
        chtreg_pkg::IDX_EVT_MASK: rd_val = {24'h000000, st.evt_mask};
        chtreg_pkg::IDX_THRESH:
          rd_val = {2'h0, st.hot_en, st.cold_c[4:0], st.hot_c, st.warm_pm[9:2], st.cool_pm[9:2]};
        default: rd_val = 32'h0000_0000;
      endcase
      next_st.hrdata = rd_val;
    end
    // events: changes of any status bit; set wins over read clear
    if (rd_stat)
      next_st.evt = st.stat0 ^ st.stat0_prev;
    else
      next_st.evt = st.evt | (st.stat0 ^ st.stat0_prev);
    // data phase write; read-only registers take nothing
    if (st.phase == chtreg_pkg::CHTREG_DATA && st.wr)
    begin
      case (st.idx)
        chtreg_pkg::IDX_THERM_CTRL: next_st.therm_ctrl = hwdata[7:0];
        chtreg_pkg::IDX_EVT_MASK: next_st.evt_mask = hwdata[7:0];
        default: next_st.evt_mask = st.evt_mask; // RULE_13
      endcase
    end
    // watchdog and register-reset restore thermistor settings
    if (wdog_reset || reg_reset)
      next_st.therm_ctrl = chtreg_pkg::THERM_CTRL_RST;
    case (st.therm_ctrl[chtreg_pkg::COOL_LSB +: 2]) // RULE_01
      2'h0: next_st.cool_pm = chtreg_pkg::COOL_PM0;
      2'h1: next_st.cool_pm = chtreg_pkg::COOL_PM1;
      2'h2: next_st.cool_pm = chtreg_pkg::COOL_PM2;
      default: next_st.cool_pm = chtreg_pkg::COOL_PM3;
    endcase
    case (st.therm_ctrl[chtreg_pkg::WARM_LSB +: 2]) // RULE_02
      2'h0: next_st.warm_pm = chtreg_pkg::WARM_PM0;
      2'h1: next_st.warm_pm = chtreg_pkg::WARM_PM1;
      2'h2: next_st.warm_pm = chtreg_pkg::WARM_PM2;
      default: next_st.warm_pm = chtreg_pkg::WARM_PM3;
    endcase
    case (st.therm_ctrl[chtreg_pkg::HOT_LSB +: 2]) // RULE_03
      2'h0: next_st.hot_c = chtreg_pkg::HOT_C0;
      2'h1: next_st.hot_c = chtreg_pkg::HOT_C1;
      2'h2: next_st.hot_c = chtreg_pkg::HOT_C2;
      default: next_st.hot_c = chtreg_pkg::HOT_C1;
    endcase
    next_st.hot_en = st.therm_ctrl[chtreg_pkg::HOT_LSB +: 2] != chtreg_pkg::HOT_DISABLE; // RULE_03
    next_st.cold_c = st.therm_ctrl[chtreg_pkg::COLD_BIT] ? chtreg_pkg::COLD_C1
                                                          : chtreg_pkg::COLD_C0; // RULE_04
    // ignore forces good and holds the four flags clear
    if (st.therm_ctrl[chtreg_pkg::IGN_BIT]) // RULE_05
    begin
      next_st.therm_ok = 1'b1;
      next_st.therm_flags = 4'h0;
    end
    else
    begin
      next_st.therm_flags = st.lvl[chtreg_pkg::THERM_SYNC_LSB +: 4];
      next_st.therm_ok = st.lvl[chtreg_pkg::THERM_SYNC_LSB +: 4] == 4'h0;
    end
    next_st.irq = |(st.evt & st.evt_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.therm_ctrl <= chtreg_pkg::THERM_CTRL_RST;
      st.icl <= chtreg_pkg::ICL_RST;
      st.cool_pm <= chtreg_pkg::COOL_PM1;
      st.warm_pm <= chtreg_pkg::WARM_PM1;
      st.hot_c <= chtreg_pkg::HOT_C1;
      st.hot_en <= 1'b1;
      st.cold_c <= chtreg_pkg::COLD_C0;
      st.therm_ok <= 1'b1;
      st.phase <= chtreg_pkg::CHTREG_IDLE;
    end
    else
      st <= next_st;
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.hrdata;
  assign irq = st.irq;
  assign cool_threshold_permille = st.cool_pm;
  assign warm_threshold_permille = st.warm_pm;
  assign output_hot_limit_c = st.hot_c;
  assign output_hot_check_en = st.hot_en;
  assign output_cold_limit_c = st.cold_c;
  assign thermistor_good = st.therm_ok;
  assign thermistor_flags = st.therm_flags;

  ////////////////////////////////////////////////////////////////////////////
  // threshold decode
  AST_COOL_MAP: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_01
    st.therm_ctrl[7:6] == 2'h0 |=> st.cool_pm == 10'd711)
    else $error("cool code 0 not mapped");

  AST_COOL_CODE2: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_01
    st.therm_ctrl[7:6] == 2'h2 |=> st.cool_pm == 10'h28F)
    else $error("cool code 2 not mapped");

  AST_COOL_CODE3: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_01
    st.therm_ctrl[7:6] == 2'h3 |=> st.cool_pm == 10'h270)
    else $error("cool code 3 not mapped");

  AST_WARM_MAP: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_02
    st.therm_ctrl[5:4] == 2'h3 |=> st.warm_pm == 10'd377)
    else $error("warm code 3 not mapped");

  AST_WARM_CODE0: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_02
    st.therm_ctrl[5:4] == 2'h0 |=> st.warm_pm == 10'h1E4)
    else $error("warm code 0 not mapped");

  AST_WARM_CODE1: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_02
    st.therm_ctrl[5:4] == 2'h1 |=> st.warm_pm == 10'h1C0)
    else $error("warm code 1 not mapped");

  AST_HOT_OFF: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_03
    st.therm_ctrl[3:2] == 2'h3 |=> !st.hot_en)
    else $error("hot check not disabled");

  AST_HOT_ON: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_03
    st.therm_ctrl[3:2] != 2'h3 |=> st.hot_en)
    else $error("hot check disabled by a limit code");

  AST_HOT_CODE0: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_03
    st.therm_ctrl[3:2] == 2'h0 |=> st.hot_c == 8'sh37)
    else $error("hot code 0 not mapped");

  AST_HOT_CODE2: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_03
    st.therm_ctrl[3:2] == 2'h2 |=> st.hot_c == 8'sh41)
    else $error("hot code 2 not mapped");

  AST_COLD_SEL: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_04
    st.therm_ctrl[1] |=> st.cold_c == -8'sd20)
    else $error("cold limit wrong");

  AST_COLD_DEF: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_04
    !st.therm_ctrl[1] |=> st.cold_c == 8'shF6)
    else $error("default cold limit wrong");

  AST_IGNORE: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_05
    st.therm_ctrl[0] |=> st.therm_flags == 4'h0 && st.therm_ok)
    else $error("ignore not honoured");

  AST_FLAGS_PASS: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_05
    !st.therm_ctrl[0] |=> st.therm_flags == $past(st.lvl[chtreg_pkg::THERM_SYNC_LSB +: 4]))
    else $error("thermistor flags not passed through");

  AST_GOOD_FLAGS: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_05
    st.therm_ok == (st.therm_flags == 4'h0))
    else $error("thermistor good disagrees with flags");

  // synchronised status path and current limit
  AST_ICL_CLAMP: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_06
    $changed(st.icl) |-> st.icl >= 9'h00A && st.icl <= 9'h14A)
    else $error("current limit out of range");

  AST_ICL_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_06
    icl_s2 != icl_s3 |=> $stable(st.icl))
    else $error("current limit latched before its word settled");

  AST_STAT_PATH: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_07
    st.s2[6] == st.s3[6] |=> ##1 st.stat0[7] == $past(st.s3[6], 2))
    else $error("current regulation bit not following input");

  AST_VREG_PATH: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_08
    st.s2[5] == st.s3[5] |=> ##1 st.stat0[6] == $past(st.s3[5], 2))
    else $error("voltage regulation bit not following input");

  AST_WD_PATH: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_09
    st.s2[4] == st.s3[4] |=> ##1 st.stat0[5] == $past(st.s3[4], 2))
    else $error("watchdog bit not following input");

  AST_PG_PATH: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_10
    st.s2[3] == st.s3[3] |=> ##1 st.stat0[3] == $past(st.s3[3], 2))
    else $error("power good bit not following input");

  AST_AUX2_PATH: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_11
    st.s2[2] == st.s3[2] |=> ##1 st.stat0[2] == $past(st.s3[2], 2))
    else $error("second auxiliary bit not following input");

  AST_AUX1_PATH: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_11
    st.s2[1] == st.s3[1] |=> ##1 st.stat0[1] == $past(st.s3[1], 2))
    else $error("first auxiliary bit not following input");

  AST_MAIN_PATH: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_12
    st.s2[0] == st.s3[0] |=> ##1 st.stat0[0] == $past(st.s3[0], 2))
    else $error("main input bit not following input");

  // bus, events and interrupt
  AST_RESV_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_13
    st.stat0[4] == 1'b0)
    else $error("reserved status bit not zero");

  AST_RESV_UPPER: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_13
    take && !hwrite && haddr[9:2] != chtreg_pkg::IDX_THRESH |=> hrdata[31:16] == 16'h0000)
    else $error("reserved read bits not zero");

  AST_WRITE_LAND: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.phase == chtreg_pkg::CHTREG_DATA && st.wr && st.idx == chtreg_pkg::IDX_THERM_CTRL
      && !wdog_reset && !reg_reset |=> st.therm_ctrl == $past(hwdata[7:0]))
    else $error("control write did not land");

  AST_WR_RST: assert property (@(posedge core_clk) disable iff (!rst_n)
    wdog_reset || reg_reset |=> st.therm_ctrl == chtreg_pkg::THERM_CTRL_RST)
    else $error("restore request did not reset control");

  AST_EVT_STICKY: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(take && !hwrite && haddr[9:2] == chtreg_pkg::IDX_EVT_STAT)
      |=> (st.evt & $past(st.evt)) == $past(st.evt))
    else $error("event bit lost without a read");

  AST_EVT_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st.stat0 ^ st.stat0_prev) != 8'h00
      |=> (st.evt & $past(st.stat0 ^ st.stat0_prev)) == $past(st.stat0 ^ st.stat0_prev))
    else $error("status change not recorded");

  AST_IRQ: assert property (@(posedge core_clk) disable iff (!rst_n)
    |(st.evt & st.evt_mask) |=> irq)
    else $error("unmasked event without interrupt");

  AST_IRQ_LOW: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st.evt & st.evt_mask) == 8'h00 |=> !irq)
    else $error("interrupt without unmasked event");

endmodule // chtreg_top

// ==== rtl/chtreg_pkg.sv ====
// Purpose: shared constants and types of the charger thermistor and status registers
// Assumes: 32-bit AHB-Lite register access, one register per word
// Notes: register index times four gives the byte address
package chtreg_pkg;
  // register indices as printed; byte address is index * 4
  localparam logic [7:0] IDX_THERM_CTRL = 8'h18;
  localparam logic [7:0] IDX_ICL = 8'h19;
  localparam logic [7:0] IDX_STAT0 = 8'h1B;
  localparam logic [7:0] IDX_STAT1 = 8'h1C;
  localparam logic [7:0] IDX_EVT_STAT = 8'h30;
  localparam logic [7:0] IDX_EVT_MASK = 8'h31;
  localparam logic [7:0] IDX_THRESH = 8'h32;
  // thermistor control field positions
  localparam int COOL_LSB = 6;
  localparam int WARM_LSB = 4;
  localparam int HOT_LSB = 2;
  localparam int COLD_BIT = 1;
  localparam int IGN_BIT = 0;
  localparam logic [7:0] THERM_CTRL_RST = 8'h54;
  localparam logic [1:0] HOT_DISABLE = 2'h3;
  // status zero bit positions
  localparam int ST_ICUR = 7;
  localparam int ST_VREG = 6;
  localparam int ST_WD = 5;
  localparam int ST_PG = 3;
  localparam int ST_AUX2 = 2;
  localparam int ST_AUX1 = 1;
  localparam int ST_MAIN = 0;
  localparam int ICL_W = 9;
  localparam logic [8:0] ICL_MIN = 9'h00A;
  localparam logic [8:0] ICL_MAX = 9'h14A;
  localparam logic [8:0] ICL_RST = 9'h000;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  // thresholds in permille of the regulator rail, per code
  localparam logic [9:0] COOL_PM0 = 10'd711;
  localparam logic [9:0] COOL_PM1 = 10'd684;
  localparam logic [9:0] COOL_PM2 = 10'd655;
  localparam logic [9:0] COOL_PM3 = 10'd624;
  localparam logic [9:0] WARM_PM0 = 10'd484;
  localparam logic [9:0] WARM_PM1 = 10'd448;
  localparam logic [9:0] WARM_PM2 = 10'd412;
  localparam logic [9:0] WARM_PM3 = 10'd377;
  // output-mode limits in signed degrees C
  localparam logic signed [7:0] HOT_C0 = 8'sd55;
  localparam logic signed [7:0] HOT_C1 = 8'sd60;
  localparam logic signed [7:0] HOT_C2 = 8'sd65;
  localparam logic signed [7:0] COLD_C0 = -8'sd10;
  localparam logic signed [7:0] COLD_C1 = -8'sd20;
  // sync word: status pins 6..0, limit code 15..7, thermistor flags 19..16
  localparam int SYNC_W = 20;
  localparam int ICL_SYNC_LSB = 7;
  localparam int THERM_SYNC_LSB = 16;

  typedef enum logic [1:0] {CHTREG_IDLE, CHTREG_DATA} chtreg_phase_e;

  typedef struct packed {
    logic [7:0] therm_ctrl;
    logic [8:0] icl;
    logic [7:0] stat0;
    logic [7:0] stat0_prev;
    logic [7:0] evt;
    logic [7:0] evt_mask;
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] lvl;
    chtreg_phase_e phase;
    logic wr;
    logic [7:0] idx;
    logic [31:0] hrdata;
    logic irq;
    logic [9:0] cool_pm;
    logic [9:0] warm_pm;
    logic signed [7:0] hot_c;
    logic hot_en;
    logic signed [7:0] cold_c;
    logic therm_ok;
    logic [3:0] therm_flags;
  } chtreg_state_s;
endpackage

// ==== verification/tb_chtreg_top.sv ====
// Purpose: self-checking bench for the thermistor control and charger status registers
// Assumes: zero-wait AHB-Lite slave, status pins settle within eight cycles
// Notes: ordinary control codes run from a table; status, limit and events follow
`timescale 1ns/1ps
module tb_chtreg_top;
  logic core_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic wdog_reset, reg_reset, output_hot_check_en, thermistor_good;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [8:0] icl;
  logic [7:0] pins;
  logic [3:0] raw, thermistor_flags;
  logic [9:0] cool_threshold_permille, warm_threshold_permille;
  logic signed [7:0] output_hot_limit_c, output_cold_limit_c;
  logic [44:0] rows [4];
  int fails = 0;
  int checked = 0;

  assign hready = hreadyout;

  chtreg_top u_dut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
    .wdog_reset(wdog_reset), .reg_reset(reg_reset), .optimized_current_limit(icl),
    .input_current_reg_flag(pins[7]), .input_voltage_reg_flag(pins[6]),
    .watchdog_expired_flag(pins[5]), .power_good_flag(pins[3]),
    .aux_input2_present(pins[2]), .aux_input1_present(pins[1]),
    .main_input_present(pins[0]), .therm_raw_flags(raw),
    .cool_threshold_permille(cool_threshold_permille),
    .warm_threshold_permille(warm_threshold_permille),
    .output_hot_limit_c(output_hot_limit_c), .output_hot_check_en(output_hot_check_en),
    .output_cold_limit_c(output_cold_limit_c), .thermistor_good(thermistor_good),
    .thermistor_flags(thermistor_flags));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    if (fails == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // entered just after a rising edge; returns at the edge that takes the data
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // the whole sequence needs a few hundred cycles; this only catches a hang
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fails++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; wdog_reset = 1'b0; reg_reset = 1'b0;
    icl = 9'h000; pins = 8'h00; raw = 4'h5;
    // {control, cool, warm, hot, hot enable, cold}
    rows = '{{8'h00, 10'h2C7, 10'h1E4, 8'h37, 1'h1, 8'hF6},
             {8'h55, 10'h2AC, 10'h1C0, 8'h3C, 1'h1, 8'hF6},
             {8'hAA, 10'h28F, 10'h19C, 8'h41, 1'h1, 8'hEC},
             {8'hFF, 10'h270, 10'h179, 8'h00, 1'h0, 8'hEC}};
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk(cool_threshold_permille, 10'h2AC);
    chk(warm_threshold_permille, 10'h1C0);
    chk({24'h0, output_hot_limit_c}, 32'h3C);
    chk({24'h0, output_cold_limit_c}, 32'hF6);
    rdchk(32'h60, 32'h54);
    rdchk(32'h64, 32'h0);
    rdchk(32'h70, 32'h0);
    rdchk(32'hC4, 32'h0);
    foreach (rows[i])
    begin
      bus(1'b1, 32'h60, {24'h0, rows[i][44:37]});
      cyc(3);
      rdchk(32'h60, {24'h0, rows[i][44:37]});
      chk(cool_threshold_permille, rows[i][36:27]);
      chk(warm_threshold_permille, rows[i][26:17]);
      chk(output_hot_check_en, rows[i][8]);
      if (rows[i][8])
        chk({24'h0, output_hot_limit_c}, rows[i][16:9]);
      chk({24'h0, output_cold_limit_c}, rows[i][7:0]);
      chk(thermistor_flags, rows[i][37] ? 4'h0 : 4'h5);
      chk(thermistor_good, rows[i][37]);
    end
    // both restore requests bring the control word back to its reset value
    wdog_reset <= 1'b1;
    @(posedge core_clk);
    wdog_reset <= 1'b0;
    cyc(2);
    rdchk(32'h60, 32'h54);
    bus(1'b1, 32'h60, 32'hFF);
    reg_reset <= 1'b1;
    @(posedge core_clk);
    reg_reset <= 1'b0;
    cyc(2);
    rdchk(32'h60, 32'h54);
    // limit follows the code, low codes clamp to the 100mA floor
    icl <= 9'h0C8;
    cyc(8);
    rdchk(32'h64, 32'hC8);
    icl <= 9'h005;
    cyc(8);
    rdchk(32'h64, 32'h0A);
    bus(1'b1, 32'h64, 32'hFFFFFFFF);
    rdchk(32'h64, 32'h0A);
    bus(1'b1, 32'h6C, 32'hFF);
    rdchk(32'h6C, 32'h0);
    rdchk(32'h100, 32'h0);
    // pin bit 4 is not wired: the reserved status bit must stay low
    for (int b = 0; b < 8; b++)
    begin
      pins <= 8'h01 << b;
      cyc(8);
      rdchk(32'h6C, (b == 4) ? 32'h0 : (32'h1 << b));
    end
    pins <= 8'hFF;
    cyc(8);
    rdchk(32'h6C, 32'hEF);
    // events: unmasked change raises the line, the status read drops it
    bus(1'b0, 32'hC0, 32'h0);
    bus(1'b1, 32'hC4, 32'h01);
    bus(1'b0, 32'hC0, 32'h0);
    cyc(3);
    chk(irq, 1'b0);
    pins <= 8'hFE;
    cyc(8);
    chk(irq, 1'b1);
    rdchk(32'hC0, 32'h01);
    cyc(3);
    chk(irq, 1'b0);
    bus(1'b1, 32'hC4, 32'h0);
    pins <= 8'hFF;
    cyc(8);
    chk(irq, 1'b0);
    rdchk(32'hC0, 32'h01);
    // second reset in mid-run
    bus(1'b1, 32'h60, 32'hAA);
    rst_n <= 1'b0;
    cyc(2);
    chk(irq, 1'b0);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk(cool_threshold_permille, 10'h2AC);
    rdchk(32'h64, 32'h0);
    rdchk(32'h60, 32'h54);
    rdchk(32'hC4, 32'h0);
    rdchk(32'hC8, 32'h363C70AB);
    summarize();
  end
endmodule // tb_chtreg_top
